/* File: dv/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk_sys,
  // answer from the register port
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit,
  // request to the register port
  output rx_irq_pkg::reg_req_t reg_req
);
  import rx_irq_pkg::*;
  int unsigned gap = 0; // idle cycles before each request
  initial reg_req = '0;
  // one-cycle write strobe; idle fields then carry the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_req.wr = 1'b0;
    reg_req.addr = ~a;
    reg_req.wdata = ~d;
  endtask : wr
  // one-cycle read strobe; answer lands at the next edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_req.rd = 1'b0;
    reg_req.addr = ~a;
    d = reg_rvalid ? reg_rdata : 8'hxx; // a missing answer never matches
    h = reg_hit;
  endtask : rd
endmodule : host_model
`default_nettype wire

/* File: dv/rx_port_irq_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module rx_port_irq_monitor
  import rx_irq_pkg::*;
#(
  parameter int NUM_PORTS = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire rx_irq_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit,
  // per-port traffic
  input wire rx_irq_pkg::port_events_t [NUM_PORTS-1:0] events,
  input wire rx_irq_pkg::source_reads_t [NUM_PORTS-1:0] src_reads,
  input wire logic [NUM_PORTS-1:0] irq_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // high once either enable register was written since reset
  logic en_wr_reg;
  logic en_wr_next;
  // d8 and d9 differ only in bit 0
  always_comb begin
    en_wr_next = en_wr_reg | (reg_req.wr & (reg_req.addr[7:1] == 7'h6c));
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      en_wr_reg <= 1'b0;
    end else begin
      en_wr_reg <= en_wr_next;
    end
  end
  // a read request for one address
  sequence s_read(logic [7:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence
  property p_read_answer; reg_req.rd |=> reg_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_no_spurious; !reg_req.rd |=> !reg_rvalid && !reg_hit; endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without read");
  property p_unmapped;
    reg_req.rd && reg_req.addr != ADDR_PORT_SELECT
      && !(reg_req.addr inside {[ADDR_RSVD_A:ADDR_STATUS_LOW]})
      |=> !reg_hit && reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read hit");
  property p_high_rsvd; s_read(ADDR_ENABLE_HIGH) |=> reg_rdata[7:3] == 5'h00; endproperty
  a_high_rsvd: assert property (p_high_rsvd) else $error("enable high spare set");
  property p_low_rsvd; s_read(ADDR_ENABLE_LOW) |=> !reg_rdata[7]; endproperty
  a_low_rsvd: assert property (p_low_rsvd) else $error("enable low spare set");
  property p_stat_rsvd; s_read(ADDR_STATUS_HIGH) |=> reg_rdata[7:5] == 3'h0; endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status spare set");
  property p_en_reset;
    reg_req.rd && reg_req.addr[7:1] == 7'h6c && !en_wr_reg |=> reg_rdata == 8'h00;
  endproperty
  a_en_reset: assert property (p_en_reset) else $error("enable not cleared");
  // gpio and sensor are never gated here, so the request must follow
  property p_gpio_irq; events[0].gpio_change |-> ##2 irq_req[0]; endproperty
  a_gpio_irq: assert property (p_gpio_irq) else $error("gpio change no request");
  property p_sens_irq;
    events[NUM_PORTS-1].sensor_change |-> ##2 irq_req[NUM_PORTS-1];
  endproperty
  a_sens_irq: assert property (p_sens_irq) else $error("sensor change no request");
endmodule : rx_port_irq_monitor
bind rx_port_interrupt_ctrl rx_port_irq_monitor #(.NUM_PORTS(NUM_PORTS)) mon_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .events(events),
  .src_reads(src_reads), .irq_req(irq_req));
`default_nettype wire

/* File: dv/test_rx_port_interrupt_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((exp) !== (got)) begin \
      $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
      num_errors++; \
    end \
  end
module test_rx_port_interrupt_ctrl;
  import rx_irq_pkg::*;
  localparam int NP = 2;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic reg_hit;
  port_events_t [NP-1:0] events = '0;
  source_reads_t [NP-1:0] src_reads = '0;
  logic [NP-1:0] irq_req;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // model: status and enable words per port, {low, high}
  logic [15:0] st [NP] = '{default: 16'h0000};
  logic [15:0] en [NP] = '{default: 16'h0000};
  logic [1:0] sens_seen [NP] = '{default: 2'h0};
  logic [7:0] rdv;
  logic [7:0] e8;
  logic [7:0] e9;
  logic hv;
  // event bit to status bit, lock first
  int ev_bit [12] = '{BIT_LOCK, BIT_PASS, BIT_PAR, BIT_CSI, BIT_BUF, BIT_CNT,
    BIT_LEN, BIT_CRC, BIT_SEQ, BIT_ENC, BIT_GPIO, BIT_SENS};
  // strobe bit to cleared status bits; sensor reads handled apart
  logic [15:0] clr_mask [6] = '{16'h0000, 16'h0000, 16'h0010, 16'h0800,
    16'h7004, 16'h0703};
  // event bit to the strobe that clears it; sensor also needs strobe 0
  int clr_of [12] = '{5, 5, 5, 3, 4, 4, 4, 5, 5, 4, 2, 1};
  rx_port_interrupt_ctrl #(.NUM_PORTS(NP)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_hit(reg_hit), .events(events), .src_reads(src_reads), .irq_req(irq_req));
  host_model host_u (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .reg_req(reg_req));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // hang guard, far above the one to two thousand cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  // expected requests: gpio and sensor always count
  function automatic logic [NP-1:0] exp_irq();
    for (int p = 0; p < NP; p++) exp_irq[p] = |(st[p] & (en[p] | UNGATED_MASK));
  endfunction : exp_irq
  task automatic check_port(input int p);
    host_u.rd(ADDR_STATUS_HIGH, rdv, hv);
    `CHK("status high", st[p][7:0], rdv)
    host_u.rd(ADDR_STATUS_LOW, rdv, hv);
    `CHK("status low", st[p][15:8], rdv)
    `CHK("irq", exp_irq(), irq_req)
  endtask : check_port
  // levels toggle, the rest pulse for one cycle
  task automatic fire(input int p, input int i);
    @(posedge clk_sys);
    #1;
    events[p][i] = (i < 2) ? ~events[p][i] : 1'b1;
    st[p][ev_bit[i]] = 1'b1;
    @(posedge clk_sys);
    #1;
    if (i >= 2) events[p][i] = 1'b0;
  endtask : fire
  task automatic clear(input int p, input int k);
    @(posedge clk_sys);
    #1;
    src_reads[p][k] = 1'b1;
    st[p] &= ~clr_mask[k];
    if (k < 2 && st[p][BIT_SENS]) begin
      sens_seen[p][k] = 1'b1;
      if (&sens_seen[p]) begin
        st[p][BIT_SENS] = 1'b0;
        sens_seen[p] = 2'h0;
      end
    end
    @(posedge clk_sys);
    #1;
    src_reads[p][k] = 1'b0;
  endtask : clear
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    rdv = 8'($urandom(32'h427a));
    repeat (10) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    // enables start clear on every port
    for (int p = 0; p < NP; p++) begin
      host_u.wr(ADDR_PORT_SELECT, 8'(p));
      host_u.rd(ADDR_PORT_SELECT, rdv, hv);
      `CHK("port select", 8'(p), rdv)
      host_u.rd(ADDR_ENABLE_HIGH, rdv, hv);
      `CHK("enable high reset", 8'h00, rdv)
      host_u.rd(ADDR_ENABLE_LOW, rdv, hv);
      `CHK("enable low reset", 8'h00, rdv)
    end
    // spare bits, read-only status, reserved store, unmapped place
    host_u.wr(ADDR_ENABLE_HIGH, 8'hff);
    host_u.rd(ADDR_ENABLE_HIGH, rdv, hv);
    `CHK("enable high mask", 8'h07, rdv)
    host_u.wr(ADDR_ENABLE_LOW, 8'hff);
    host_u.rd(ADDR_ENABLE_LOW, rdv, hv);
    `CHK("enable low mask", 8'h7f, rdv)
    host_u.wr(ADDR_STATUS_HIGH, 8'hff);
    host_u.rd(ADDR_STATUS_HIGH, rdv, hv);
    `CHK("status write", 8'h00, rdv)
    e8 = 8'($urandom());
    host_u.wr(ADDR_RSVD_A, e8);
    host_u.rd(ADDR_RSVD_A, rdv, hv);
    `CHK("reserved store", e8, rdv)
    `CHK("mapped hit", 1'b1, hv)
    host_u.rd(8'h55, rdv, hv);
    `CHK("unmapped hit", 1'b0, hv)
    // each enable seen set and clear over two passes
    for (int p = 0; p < NP; p++) begin
      e8 = 8'($urandom());
      e9 = 8'($urandom());
      for (int pass = 0; pass < 2; pass++) begin
        host_u.gap = $urandom_range(0, 2);
        host_u.wr(ADDR_PORT_SELECT, 8'(p));
        host_u.wr(ADDR_ENABLE_HIGH, pass ? ~e8 : e8);
        host_u.wr(ADDR_ENABLE_LOW, pass ? ~e9 : e9);
        en[p] = {(pass ? ~e9 : e9) & ENABLE_LOW_MASK, (pass ? ~e8 : e8) & ENABLE_HIGH_MASK};
        // one event at a time, so each enable alone decides the request
        for (int i = 0; i < 12; i++) begin
          fire(p, i);
          check_port(p);
          clear(p, clr_of[i]);
          if (i == 11) clear(p, 0);
          check_port(p);
        end
        for (int i = 0; i < 12; i++) begin
          fire(p, i);
          check_port(p);
        end
        for (int k = 5; k >= 0; k--) begin
          clear(p, k);
          check_port(p);
        end
      end
    end
    // the other port kept its own copy
    host_u.wr(ADDR_PORT_SELECT, 8'h00);
    host_u.rd(ADDR_ENABLE_HIGH, rdv, hv);
    `CHK("port copy", en[0][7:0], rdv)
    // a second reset in mid-run must clear select and enables again
    host_u.wr(ADDR_PORT_SELECT, 8'h01);
    @(posedge clk_sys);
    #1;
    reset_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    en[0] = 16'h0000;
    en[1] = 16'h0000;
    host_u.rd(ADDR_PORT_SELECT, rdv, hv);
    `CHK("select after reset", RESET_PORT_SELECT, rdv)
    host_u.rd(ADDR_ENABLE_HIGH, rdv, hv);
    `CHK("enable high after reset", 8'h00, rdv)
    host_u.rd(ADDR_ENABLE_LOW, rdv, hv);
    `CHK("enable low after reset", 8'h00, rdv)
    complete_run();
  end
endmodule : test_rx_port_interrupt_ctrl
`default_nettype wire

/* File: hw/rx_irq_pkg.sv */
package rx_irq_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_PORT_SELECT = 8'h4c;
  localparam logic [7:0] ADDR_RSVD_A = 8'hd6;
  localparam logic [7:0] ADDR_RSVD_B = 8'hd7;
  localparam logic [7:0] ADDR_ENABLE_HIGH = 8'hd8;
  localparam logic [7:0] ADDR_ENABLE_LOW = 8'hd9;
  localparam logic [7:0] ADDR_STATUS_HIGH = 8'hda;
  localparam logic [7:0] ADDR_STATUS_LOW = 8'hdb;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_PORT_SELECT = 8'h00;

  // implemented bits of each register, the rest reads zero
  localparam logic [7:0] ENABLE_HIGH_MASK = 8'h07;
  localparam logic [7:0] ENABLE_LOW_MASK = 8'h7f;
  localparam logic [7:0] STATUS_HIGH_MASK = 8'h1f;
  localparam logic [7:0] STATUS_LOW_MASK = 8'h7f;

  // field positions in the 16-bit {low, high} status/enable word
  localparam int unsigned BIT_CRC = 0;
  localparam int unsigned BIT_SEQ = 1;
  localparam int unsigned BIT_ENC = 2;
  localparam int unsigned BIT_SENS = 3;
  localparam int unsigned BIT_GPIO = 4;
  localparam int unsigned BIT_LOCK = 8;
  localparam int unsigned BIT_PASS = 9;
  localparam int unsigned BIT_PAR = 10;
  localparam int unsigned BIT_CSI = 11;
  localparam int unsigned BIT_BUF = 12;
  localparam int unsigned BIT_CNT = 13;
  localparam int unsigned BIT_LEN = 14;
  localparam int unsigned STATUS_W = 16;

  // gpio and sensor sources are gated by their own enables upstream
  localparam logic [15:0] UNGATED_MASK = 16'h0018;

  // per-port event inputs: pulses, except port_valid and lock (levels)
  typedef struct packed {
    logic sensor_change;
    logic gpio_change;
    logic enc_error;
    logic seq_error;
    logic crc_error;
    logic line_len_change;
    logic line_cnt_change;
    logic buffer_overflow;
    logic csi_error;
    logic parity_error;
    logic port_valid;
    logic lock;
  } port_events_t;

  // per-port one-cycle strobes: software read a source status register
  typedef struct packed {
    logic status_one;
    logic status_two;
    logic csi_status;
    logic gpio_status;
    logic sensor_rise;
    logic sensor_fall;
  } source_reads_t;

  // register access request from the control-bus target
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : rx_irq_pkg

/* File: hw/rx_port_interrupt_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module rx_port_interrupt_ctrl #(
  parameter int NUM_PORTS = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register access from the control-bus target
  input wire rx_irq_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  // per-port events from the receive logic
  input wire rx_irq_pkg::port_events_t [NUM_PORTS-1:0] events,
  // per-port source status register read strobes
  input wire rx_irq_pkg::source_reads_t [NUM_PORTS-1:0] src_reads,
  // per-port interrupt requests
  output logic [NUM_PORTS-1:0] irq_req
);
  import rx_irq_pkg::*;

  localparam int IDX_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

  // true for every address this block answers with reg_hit high
  function automatic logic addr_is_mapped(input logic [7:0] addr);
    addr_is_mapped = (addr == ADDR_PORT_SELECT) || (addr == ADDR_RSVD_A) ||
                     (addr == ADDR_RSVD_B) || (addr == ADDR_ENABLE_HIGH) ||
                     (addr == ADDR_ENABLE_LOW) || (addr == ADDR_STATUS_HIGH) ||
                     (addr == ADDR_STATUS_LOW);
  endfunction : addr_is_mapped

  // true for addresses that have a copy per receive port
  function automatic logic addr_is_per_port(input logic [7:0] addr);
    addr_is_per_port = addr_is_mapped(addr) && (addr != ADDR_PORT_SELECT);
  endfunction : addr_is_per_port

  // port select register
  logic [7:0] sel_reg;
  logic [7:0] sel_next;
  logic [IDX_W-1:0] port_idx; // selected receive port
  logic port_ok; // low select bits name an existing port

  // per-port software registers
  logic [7:0] en_hi_reg [NUM_PORTS];
  logic [7:0] en_hi_next [NUM_PORTS];
  logic [7:0] en_lo_reg [NUM_PORTS];
  logic [7:0] en_lo_next [NUM_PORTS];
  logic [7:0] rsvd_a_reg [NUM_PORTS];
  logic [7:0] rsvd_a_next [NUM_PORTS];
  logic [7:0] rsvd_b_reg [NUM_PORTS];
  logic [7:0] rsvd_b_next [NUM_PORTS];

  // level history for change detection
  logic [NUM_PORTS-1:0] lock_prev_reg;
  logic [NUM_PORTS-1:0] lock_prev_next;
  logic [NUM_PORTS-1:0] pass_prev_reg;
  logic [NUM_PORTS-1:0] pass_prev_next;
  logic primed_reg; // history holds real samples
  logic primed_next;

  // sensor clear needs both rising and falling reads
  logic [NUM_PORTS-1:0] rise_seen_reg;
  logic [NUM_PORTS-1:0] rise_seen_next;
  logic [NUM_PORTS-1:0] fall_seen_reg;
  logic [NUM_PORTS-1:0] fall_seen_next;
  logic [NUM_PORTS-1:0] sens_clear; // both reads done while pending

  // per-port sticky status, set and clear vectors
  logic [STATUS_W-1:0] status [NUM_PORTS];
  logic [STATUS_W-1:0] set_vec [NUM_PORTS];
  logic [STATUS_W-1:0] clr_vec [NUM_PORTS];

  // response and request outputs
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic hit_reg;
  logic hit_next;
  logic [NUM_PORTS-1:0] irq_reg;
  logic [NUM_PORTS-1:0] irq_next;

  // only the low IDX_W select bits pick a port; upper bits are ignored
  assign port_idx = sel_reg[IDX_W-1:0];
  assign port_ok = (int'(port_idx) < NUM_PORTS);

  // port select next value
  always_comb begin
    sel_next = sel_reg;
    if (reg_req.wr && (reg_req.addr == ADDR_PORT_SELECT)) begin
      sel_next = reg_req.wdata;
    end
  end

  // port select register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sel_reg <= RESET_PORT_SELECT;
    end else begin
      sel_reg <= sel_next;
    end
  end

  // writes reach only the selected port's copy
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      en_hi_next[p] = en_hi_reg[p];
      en_lo_next[p] = en_lo_reg[p];
      rsvd_a_next[p] = rsvd_a_reg[p];
      rsvd_b_next[p] = rsvd_b_reg[p];
      if (reg_req.wr && port_ok && (int'(port_idx) == p)) begin
        unique case (reg_req.addr)
          // reserved bits are dropped on write
          ADDR_ENABLE_HIGH: en_hi_next[p] = reg_req.wdata & ENABLE_HIGH_MASK;
          ADDR_ENABLE_LOW: en_lo_next[p] = reg_req.wdata & ENABLE_LOW_MASK;
          // reserved storage bytes are kept as written
          ADDR_RSVD_A: rsvd_a_next[p] = reg_req.wdata;
          ADDR_RSVD_B: rsvd_b_next[p] = reg_req.wdata;
          // status and unmapped addresses ignore writes
          default: begin
          end
        endcase
      end
    end
  end

  // per-port software registers; enables start cleared
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        en_hi_reg[p] <= RESET_BYTE;
        en_lo_reg[p] <= RESET_BYTE;
        rsvd_a_reg[p] <= RESET_BYTE;
        rsvd_b_reg[p] <= RESET_BYTE;
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        en_hi_reg[p] <= en_hi_next[p];
        en_lo_reg[p] <= en_lo_next[p];
        rsvd_a_reg[p] <= rsvd_a_next[p];
        rsvd_b_reg[p] <= rsvd_b_next[p];
      end
    end
  end

  // level history; first sample after reset only primes it, so a lock
  // already up at release is not reported as a change
  always_comb begin
    primed_next = 1'b1;
    for (int p = 0; p < NUM_PORTS; p++) begin
      lock_prev_next[p] = events[p].lock;
      pass_prev_next[p] = events[p].port_valid;
    end
  end

  // level history registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      primed_reg <= 1'b0;
      lock_prev_reg <= '0;
      pass_prev_reg <= '0;
    end else begin
      primed_reg <= primed_next;
      lock_prev_reg <= lock_prev_next;
      pass_prev_reg <= pass_prev_next;
    end
  end

  // set and clear vectors for each port
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      set_vec[p] = '0;
      clr_vec[p] = '0;
      set_vec[p][BIT_CRC] = events[p].crc_error;
      set_vec[p][BIT_SEQ] = events[p].seq_error;
      set_vec[p][BIT_ENC] = events[p].enc_error;
      set_vec[p][BIT_SENS] = events[p].sensor_change;
      set_vec[p][BIT_GPIO] = events[p].gpio_change;
      set_vec[p][BIT_LOCK] = primed_reg && (events[p].lock != lock_prev_reg[p]);
      set_vec[p][BIT_PASS] = primed_reg && (events[p].port_valid != pass_prev_reg[p]);
      set_vec[p][BIT_PAR] = events[p].parity_error;
      set_vec[p][BIT_CSI] = events[p].csi_error;
      set_vec[p][BIT_BUF] = events[p].buffer_overflow;
      set_vec[p][BIT_CNT] = events[p].line_cnt_change;
      set_vec[p][BIT_LEN] = events[p].line_len_change;
      // first status register clears the control-channel and link bits
      clr_vec[p][BIT_CRC] = src_reads[p].status_one;
      clr_vec[p][BIT_SEQ] = src_reads[p].status_one;
      clr_vec[p][BIT_LOCK] = src_reads[p].status_one;
      clr_vec[p][BIT_PASS] = src_reads[p].status_one;
      clr_vec[p][BIT_PAR] = src_reads[p].status_one;
      // second status register clears encoding and video bits
      clr_vec[p][BIT_ENC] = src_reads[p].status_two;
      clr_vec[p][BIT_BUF] = src_reads[p].status_two;
      clr_vec[p][BIT_CNT] = src_reads[p].status_two;
      clr_vec[p][BIT_LEN] = src_reads[p].status_two;
      // detail for CSI errors lives in the CSI receiver status register
      clr_vec[p][BIT_CSI] = src_reads[p].csi_status;
      clr_vec[p][BIT_GPIO] = src_reads[p].gpio_status;
      clr_vec[p][BIT_SENS] = sens_clear[p];
    end
  end

  // sensor status waits for both edge-status reads, in either order
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      sens_clear[p] = status[p][BIT_SENS] &&
                      (rise_seen_reg[p] || src_reads[p].sensor_rise) &&
                      (fall_seen_reg[p] || src_reads[p].sensor_fall);
      if (!status[p][BIT_SENS] || sens_clear[p]) begin
        // a new event during the clear must see both reads again
        rise_seen_next[p] = 1'b0;
        fall_seen_next[p] = 1'b0;
      end else begin
        rise_seen_next[p] = rise_seen_reg[p] || src_reads[p].sensor_rise;
        fall_seen_next[p] = fall_seen_reg[p] || src_reads[p].sensor_fall;
      end
    end
  end

  // sensor read tracking registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rise_seen_reg <= '0;
      fall_seen_reg <= '0;
    end else begin
      rise_seen_reg <= rise_seen_next;
      fall_seen_reg <= fall_seen_next;
    end
  end

  // one sticky status bank per receive port
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_bank
    sticky_flags #(
      .WIDTH(STATUS_W)
    ) u_flags (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .set_bits(set_vec[g]),
      .clr_bits(clr_vec[g]),
      .flags(status[g])
    );
  end

  // request while any enabled status, or any gpio or sensor status, is pending
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      irq_next[p] = |(status[p] & ({en_lo_reg[p], en_hi_reg[p]} | UNGATED_MASK));
    end
  end

  // the enable bits gate each condition except gpio and sensor onto the request
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_reg <= '0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // read mux; reading this block's status does not clear it
  always_comb begin
    rdata_next = 8'h00;
    rvalid_next = reg_req.rd;
    hit_next = reg_req.rd && addr_is_mapped(reg_req.addr);
    if (reg_req.rd && (reg_req.addr == ADDR_PORT_SELECT)) begin
      rdata_next = sel_reg;
    end else if (reg_req.rd && port_ok && addr_is_per_port(reg_req.addr)) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (int'(port_idx) == p) begin
          unique case (reg_req.addr)
            ADDR_RSVD_A: rdata_next = rsvd_a_reg[p];
            ADDR_RSVD_B: rdata_next = rsvd_b_reg[p];
            ADDR_ENABLE_HIGH: rdata_next = en_hi_reg[p] & ENABLE_HIGH_MASK;
            ADDR_ENABLE_LOW: rdata_next = en_lo_reg[p] & ENABLE_LOW_MASK;
            ADDR_STATUS_HIGH: rdata_next = status[p][7:0] & STATUS_HIGH_MASK;
            ADDR_STATUS_LOW: rdata_next = status[p][15:8] & STATUS_LOW_MASK;
            default: rdata_next = 8'h00;
          endcase
        end
      end
    end
  end

  // response registers; unmapped reads answer zero with hit low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      hit_reg <= hit_next;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign reg_hit = hit_reg;
  assign irq_req = irq_reg;

endmodule : rx_port_interrupt_ctrl
`default_nettype wire

/* File: hw/sticky_flags.sv */
`timescale 1ns/10ps
`default_nettype none
module sticky_flags #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // set and clear requests
  input wire logic [WIDTH-1:0] set_bits,
  input wire logic [WIDTH-1:0] clr_bits,
  // held flags
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_reg; // held status
  logic [WIDTH-1:0] flags_next; // next status

  // set beats clear so an event in the clearing cycle is not lost
  always_comb begin
    flags_next = (flags_reg & ~clr_bits) | set_bits;
  end

  // register only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule : sticky_flags
`default_nettype wire
